//--- core/short_protect_pkg.sv
package short_protect_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_SETTINGS = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_STATE = 12'h00C;

  // Settings word fields
  localparam int HS_THR_LSB = 7;
  localparam int FREQ_ADJ_EN_BIT = 9;
  localparam int FREQ_DIR_BIT = 10;
  localparam int SETTINGS_MSB = 10;
  localparam logic [10:0] SETTINGS_RESET = 11'h000;

  // Status and mask bit positions
  localparam int EV_HS_SHORT = 0;
  localparam int EV_LS_SHORT = 1;
  localparam int EV_LATCH_SET = 2;
  localparam int EV_LATCH_CLR = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // State register fields
  localparam int ST_LATCHED_BIT = 0;
  localparam int ST_HS_CNT_LSB = 4;
  localparam int ST_LS_CNT_LSB = 8;

  // Short protection
  localparam logic [2:0] SHORT_LIMIT = 3'h7;
  localparam logic [9:0] HS_THR_300 = 10'h12C;
  localparam logic [9:0] HS_THR_500 = 10'h1F4;
  localparam logic [9:0] HS_THR_700 = 10'h2BC;
  localparam logic [9:0] HS_THR_900 = 10'h384;
  localparam logic [9:0] LS_THR_MV = 10'h06E;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_NS = 200;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BLANK_COUNT = 4'(BLANK_CYC);
  localparam logic [4:0] PERIOD_NOM = 5'h0D;
  localparam logic [4:0] PERIOD_SLOW = 5'h10;
  localparam logic [4:0] PERIOD_FAST = 5'h0B;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_LATCHED = 1'b1
  } prot_state_e;

endpackage : short_protect_pkg

//--- core/short_count_if.sv
`timescale 1ns/1ps
`default_nettype none
// Signals between the protection core and one short-event counter
interface short_count_if;
  logic gate_on;
  logic cmp;
  logic ocp_cut;
  logic clear;
  logic [2:0] count;
  logic reached;
  logic event_hit;
  modport counter (input gate_on, cmp, ocp_cut, clear, output count, reached, event_hit);
  modport ctrl (output gate_on, cmp, ocp_cut, clear, input count, reached, event_hit);
endinterface : short_count_if
`default_nettype wire

//--- core/short_event_counter.sv
`timescale 1ns/1ps
`default_nettype none
module short_event_counter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core link
  short_count_if.counter cnt
);

  logic gate_prev;
  logic on_window;
  logic seen;
  logic [3:0] blank_left;
  logic [2:0] count;
  logic event_hit;

  // Turn-on edge and evaluation window
  wire turn_on = cnt.gate_on & ~gate_prev;
  wire blank_done = (blank_left == 4'h0);
  wire hit = on_window & blank_done & cnt.cmp & ~seen & cnt.gate_on & ~cnt.ocp_cut;
  wire at_limit = (count == short_protect_pkg::SHORT_LIMIT);

  // Blanking timer restarts at every turn-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_prev <= 1'b0;
      blank_left <= 4'h0;
    end else begin
      gate_prev <= cnt.gate_on;
      if (turn_on) begin
        blank_left <= short_protect_pkg::BLANK_COUNT;
      end else if (!blank_done) begin
        blank_left <= blank_left - 4'h1;
      end
    end
  end

  // Window closes when the gate drops or peak current cuts the on-time during blanking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_window <= 1'b0;
      seen <= 1'b0;
    end else if (cnt.clear) begin
      on_window <= 1'b0;
      seen <= 1'b0;
    end else if (turn_on) begin
      on_window <= ~cnt.ocp_cut; // Peak cut in the turn-on cycle is inside blanking
      seen <= 1'b0;
    end else if (!cnt.gate_on || (cnt.ocp_cut && !blank_done)) begin
      on_window <= 1'b0;
    end else if (hit) begin
      seen <= 1'b1;
    end
  end

  // Saturating event count, no time window so slow accumulation still counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 3'h0;
      event_hit <= 1'b0;
    end else begin
      event_hit <= hit & ~cnt.clear;
      if (cnt.clear) begin
        count <= 3'h0;
      end else if (hit && !at_limit) begin
        count <= count + 3'h1;
      end
    end
  end

  assign cnt.count = count;
  assign cnt.reached = at_limit;
  assign cnt.event_hit = event_hit;

endmodule : short_event_counter
`default_nettype wire

//--- core/short_protect_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module short_protect_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog and gate-driver pins
  input wire logic supply_below_lockout,
  input wire logic adapter_detect_low,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic hs_short_cmp,
  input wire logic ls_short_cmp,
  input wire logic peak_ocp,
  // Converter control
  output logic sw_cycle_start,
  output logic [9:0] hs_short_threshold_mv,
  output logic [9:0] ls_short_threshold_mv,
  output logic charger_enable,
  // Power path switches
  output logic adapter_path_switch,
  output logic reverse_block_switch,
  output logic battery_path_switch,
  // Interrupt
  output logic irq
);

  localparam int NPIN = 7;

  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [short_protect_pkg::SETTINGS_MSB:0] converter_settings_word;
  logic [short_protect_pkg::EV_W-1:0] status;
  logic [short_protect_pkg::EV_W-1:0] mask;
  short_protect_pkg::prot_state_e state;
  short_protect_pkg::prot_state_e next_state;
  logic [4:0] period_cnt;
  logic [9:0] hs_thr;
  logic [31:0] next_prdata;

  short_count_if hs_if ();
  short_count_if ls_if ();

  // Two-flop synchronisers for every pin input
  wire [NPIN-1:0] pin_raw = {peak_ocp, ls_short_cmp, hs_short_cmp, ls_gate, hs_gate,
                             adapter_detect_low, supply_below_lockout};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire s_supply_low = pin_sync[0];
  wire s_adapter_low = pin_sync[1];
  wire s_hs_gate = pin_sync[2];
  wire s_ls_gate = pin_sync[3];
  wire s_hs_cmp = pin_sync[4];
  wire s_ls_cmp = pin_sync[5];
  wire s_peak_ocp = pin_sync[6];

  // Register decode
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  wire apb_access = psel & penable;
  wire sel_settings = addr_is(paddr, short_protect_pkg::ADDR_SETTINGS);
  wire sel_status = addr_is(paddr, short_protect_pkg::ADDR_STATUS);
  wire sel_mask = addr_is(paddr, short_protect_pkg::ADDR_MASK);
  wire sel_state = addr_is(paddr, short_protect_pkg::ADDR_STATE);
  wire sel_any = sel_settings | sel_status | sel_mask | sel_state;
  wire wr_settings = apb_access & pwrite & sel_settings;
  wire wr_mask = apb_access & pwrite & sel_mask;
  wire rd_status = apb_access & ~pwrite & sel_status;

  // Zero-wait slave, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access & ~sel_any;

  // Settings and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_settings_word <= short_protect_pkg::SETTINGS_RESET;
      mask <= short_protect_pkg::MASK_RESET;
    end else begin
      if (wr_settings) begin
        converter_settings_word <= pwdata[short_protect_pkg::SETTINGS_MSB:0];
      end
      if (wr_mask) begin
        mask <= pwdata[short_protect_pkg::EV_W-1:0];
      end
    end
  end

  // Frequency selection from the settings word
  wire freq_adj_en = converter_settings_word[short_protect_pkg::FREQ_ADJ_EN_BIT];
  wire freq_dir_up = converter_settings_word[short_protect_pkg::FREQ_DIR_BIT];
  wire [4:0] adj_period = freq_dir_up ? short_protect_pkg::PERIOD_FAST
                                      : short_protect_pkg::PERIOD_SLOW;
  wire [4:0] period_sel = freq_adj_en ? adj_period : short_protect_pkg::PERIOD_NOM;
  wire period_end = (period_cnt >= period_sel - 5'h1);

  // Switching-cycle divider, start pulse held off while latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_cnt <= 5'h00;
      sw_cycle_start <= 1'b0;
    end else begin
      period_cnt <= period_end ? 5'h00 : period_cnt + 5'h01;
      sw_cycle_start <= period_end & (next_state == short_protect_pkg::ST_RUN); // Same edge as path switches
    end
  end

  // High-side threshold decode
  wire [1:0] hs_code = converter_settings_word[short_protect_pkg::HS_THR_LSB +: 2];
  always_comb begin
    unique case (hs_code)
      2'b00: hs_thr = short_protect_pkg::HS_THR_300;
      2'b01: hs_thr = short_protect_pkg::HS_THR_500;
      2'b10: hs_thr = short_protect_pkg::HS_THR_700;
      2'b11: hs_thr = short_protect_pkg::HS_THR_900;
    endcase
  end

  // Threshold outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_short_threshold_mv <= short_protect_pkg::HS_THR_300;
      ls_short_threshold_mv <= short_protect_pkg::LS_THR_MV;
    end else begin
      hs_short_threshold_mv <= hs_thr;
      ls_short_threshold_mv <= short_protect_pkg::LS_THR_MV;
    end
  end

  // Latch release condition clears counters as well
  wire release_cond = s_supply_low | s_adapter_low;

  // High-side counter: peak overcurrent can cut its on-time
  assign hs_if.gate_on = s_hs_gate;
  assign hs_if.cmp = s_hs_cmp;
  assign hs_if.ocp_cut = s_peak_ocp;
  assign hs_if.clear = release_cond;

  // Low-side counter
  assign ls_if.gate_on = s_ls_gate;
  assign ls_if.cmp = s_ls_cmp;
  assign ls_if.ocp_cut = 1'b0;
  assign ls_if.clear = release_cond;

  short_event_counter u_hs_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cnt(hs_if)
  );

  short_event_counter u_ls_counter (
    .pclk(pclk),
    .presetn(presetn),
    .cnt(ls_if)
  );

  // Protection state: either counter at seven latches off
  wire any_reached = hs_if.reached | ls_if.reached;
  always_comb begin
    next_state = state;
    unique case (state)
      short_protect_pkg::ST_RUN: begin
        if (any_reached && !release_cond) begin
          next_state = short_protect_pkg::ST_LATCHED;
        end
      end
      short_protect_pkg::ST_LATCHED: begin
        if (release_cond) begin
          next_state = short_protect_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= short_protect_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  wire latch_set_ev = (state == short_protect_pkg::ST_RUN) & (next_state == short_protect_pkg::ST_LATCHED);
  wire latch_clr_ev = (state == short_protect_pkg::ST_LATCHED) & (next_state == short_protect_pkg::ST_RUN);
  wire next_latched = (next_state == short_protect_pkg::ST_LATCHED);

  // Power path and converter enable outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adapter_path_switch <= 1'b0;
      reverse_block_switch <= 1'b0;
      battery_path_switch <= 1'b0;
      charger_enable <= 1'b0;
    end else if (next_latched) begin
      adapter_path_switch <= 1'b0;
      reverse_block_switch <= 1'b0;
      battery_path_switch <= 1'b1;
      charger_enable <= 1'b0;
    end else begin
      adapter_path_switch <= ~s_adapter_low;
      reverse_block_switch <= ~s_adapter_low;
      battery_path_switch <= s_adapter_low;
      charger_enable <= ~release_cond;
    end
  end

  // Sticky status, cleared by reading; a new event wins over the clear
  wire [short_protect_pkg::EV_W-1:0] ev_set = {latch_clr_ev, latch_set_ev, ls_if.event_hit, hs_if.event_hit};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= (rd_status ? '0 : status) | ev_set;
      irq <= |(((rd_status ? '0 : status) | ev_set) & mask);
    end
  end

  // Read data mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_settings) begin
      next_prdata[short_protect_pkg::SETTINGS_MSB:0] = converter_settings_word;
    end else if (sel_status) begin
      next_prdata[short_protect_pkg::EV_W-1:0] = status;
    end else if (sel_mask) begin
      next_prdata[short_protect_pkg::EV_W-1:0] = mask;
    end else if (sel_state) begin
      next_prdata[short_protect_pkg::ST_LATCHED_BIT] = (state == short_protect_pkg::ST_LATCHED);
      next_prdata[short_protect_pkg::ST_HS_CNT_LSB +: 3] = hs_if.count;
      next_prdata[short_protect_pkg::ST_LS_CNT_LSB +: 3] = ls_if.count;
    end
  end

  assign prdata = next_prdata;

endmodule : short_protect_ctrl
`default_nettype wire

//--- bench/short_protect_props.sv
`timescale 1ns/1ps
`default_nettype none
module short_protect_props (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Pins and outputs
  input wire logic supply_below_lockout,
  input wire logic adapter_detect_low,
  input wire logic sw_cycle_start,
  input wire logic [9:0] hs_short_threshold_mv,
  input wire logic [9:0] ls_short_threshold_mv,
  input wire logic charger_enable,
  input wire logic adapter_path_switch,
  input wire logic reverse_block_switch,
  input wire logic battery_path_switch
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Release held long enough to pass the synchronizers
  sequence s_release;
    (supply_below_lockout || adapter_detect_low) [*4];
  endsequence
  sequence s_adapter;
    !adapter_detect_low [*4];
  endsequence
  sequence s_set_write;
    psel && penable && pready && pwrite && paddr == 12'h000;
  endsequence
  // Threshold code to millivolts, 200 mV steps from 300
  function automatic logic [9:0] thr(input logic [1:0] c);
    return 10'h12C + 10'h0C8 * 10'(c);
  endfunction : thr
  a_ls_thr_fixed: assert property (ls_short_threshold_mv == 10'h06E)
    else $error("low-side threshold moved");
  a_hs_thr_legal: assert property (hs_short_threshold_mv inside {10'h12C, 10'h1F4, 10'h2BC, 10'h384})
    else $error("high-side threshold off table");
  a_hs_thr_write: assert property (s_set_write |-> ##2 hs_short_threshold_mv == thr($past(pwdata[8:7], 2)))
    else $error("high-side threshold ignores settings");
  a_path_pair: assert property (adapter_path_switch == reverse_block_switch)
    else $error("adapter and reverse switches differ");
  a_path_excl: assert property (adapter_path_switch |-> !battery_path_switch)
    else $error("adapter and battery paths both on");
  a_cycle_gap: assert property (sw_cycle_start |=> !sw_cycle_start [*8])
    else $error("switching period too short");
  a_release_off: assert property (s_release |-> !charger_enable)
    else $error("charger on during release");
  a_latched_quiet: assert property (s_adapter ##0 battery_path_switch |-> !sw_cycle_start && !charger_enable)
    else $error("latched charger still switching");
endmodule : short_protect_props
`default_nettype wire

//--- bench/apb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  // Clock
  input wire logic pclk,
  // Register bus
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // Setup, access held until ready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data shows no stale value
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

//--- bench/short_protect_and_freq_adjust_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module short_protect_and_freq_adjust_tb_top;
  logic pclk, presetn, pwrite, psel, penable, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic supply_below_lockout, adapter_detect_low, hs_gate, ls_gate, hs_short_cmp, ls_short_cmp, peak_ocp;
  logic sw_cycle_start, charger_enable, adapter_path_switch, reverse_block_switch, battery_path_switch;
  logic [9:0] hs_short_threshold_mv, ls_short_threshold_mv;
  int num_errors = 0, num_checks = 0, cycles = 0, hs_n = 0, ls_n = 0, lat = 0, st = 0, i, s;
  short_protect_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .supply_below_lockout, .adapter_detect_low, .hs_gate, .ls_gate, .hs_short_cmp,
    .ls_short_cmp, .peak_ocp, .sw_cycle_start, .hs_short_threshold_mv, .ls_short_threshold_mv,
    .charger_enable, .adapter_path_switch, .reverse_block_switch, .battery_path_switch, .irq);
  apb_host_model host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask : rd
  // Counters, latch and status read back against the model
  task automatic rd_all();
    rd(12'h00C, lat + hs_n * 16 + ls_n * 256);
    rd(12'h004, st);
    st = 0;
  endtask : rd_all
  // Cycles from one switching pulse to the next
  task automatic period(input int x);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (sw_cycle_start !== 1'b1 && n < 40);
    end
    chk(n, x);
  endtask : period
  // Gate on-periods; late compare after blanking, ocp cut at turn-on
  task automatic burst(input bit low, input bit late, input bit ocp, input int n);
    bit c;
    repeat (n) begin
      for (int k = 0; k < 10; k++) begin
        @(posedge pclk);
        c = late ? (k > 2 && k < 6) : (k == 0);
        hs_gate <= !low && k < 6;
        ls_gate <= low && k < 6;
        hs_short_cmp <= !low && c;
        ls_short_cmp <= low && c;
        peak_ocp <= ocp && k == 0;
      end
      if (late && !ocp) begin
        if (low) ls_n++;
        else hs_n++;
        st |= low ? 2 : 1;
        if (hs_n == 7 || ls_n == 7) lat = 1;
        if (lat == 1) st |= 4;
      end
    end
  endtask : burst
  // Hold a release pin, then clear the model
  task automatic release_by(input bit sup);
    @(posedge pclk);
    supply_below_lockout <= sup;
    adapter_detect_low <= !sup;
    repeat (6) @(posedge pclk);
    supply_below_lockout <= 1'b0;
    adapter_detect_low <= 1'b0;
    repeat (6) @(posedge pclk);
    {hs_n, ls_n, lat} = '0;
    st |= 8;
  endtask : release_by
  // Main sequence
  initial begin
    {presetn, supply_below_lockout, adapter_detect_low, hs_gate, ls_gate} = '0;
    {hs_short_cmp, ls_short_cmp, peak_ocp} = '0;
    s = $urandom(32051);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(ls_short_threshold_mv, 110);
    chk(hs_short_threshold_mv, 300);
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    chk(e, 1);
    for (i = 0; i < 4; i++) begin
      d = (i << 7) | ($urandom & 32'h7F);
      wr(12'h000, d);
      repeat (3) @(posedge pclk);
      chk(hs_short_threshold_mv, 300 + 200 * i);
      rd(12'h000, d);
    end
    wr(12'h000, 32'h0);
    period(13);
    wr(12'h000, 32'h200);
    period(16);
    wr(12'h000, 32'h600);
    period(11);
    wr(12'h000, 32'h400);
    period(13);
    wr(12'h008, 32'h1);
    burst(0, 0, 0, 3);
    burst(0, 1, 1, 3);
    rd_all();
    chk(irq, 0);
    burst(0, 1, 0, $urandom_range(6, 1));
    burst(1, 1, 0, $urandom_range(6, 1));
    chk(irq, 1);
    rd_all();
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    burst(0, 1, 0, 7 - hs_n);
    rd(12'h00C, lat + hs_n * 16 + ls_n * 256);
    chk({adapter_path_switch, reverse_block_switch, battery_path_switch, charger_enable}, 4'h2);
    release_by(0);
    rd_all();
    chk({adapter_path_switch, battery_path_switch, charger_enable}, 3'h5);
    burst(1, 1, 0, 7);
    rd(12'h00C, 32'h701);
    release_by(1);
    rd_all();
    report_and_stop();
  end
endmodule : short_protect_and_freq_adjust_tb_top
bind short_protect_ctrl short_protect_props chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .supply_below_lockout, .adapter_detect_low, .sw_cycle_start, .hs_short_threshold_mv,
  .ls_short_threshold_mv, .charger_enable, .adapter_path_switch, .reverse_block_switch, .battery_path_switch);
`default_nettype wire
